// *** design/gpe_event_pkg.sv ***
package gpe_event_pkg;

    // Register widths and source count
    localparam int unsigned REG_W = 8;
    localparam int unsigned NUM_SRC = 6;
    localparam int unsigned ADDR_W = 4;

    // Register offsets inside the event window
    localparam logic [3:0] OFS_GPE0_STS1 = 4'h0;
    localparam logic [3:0] OFS_GPE0_STS2 = 4'h1;
    localparam logic [3:0] OFS_GPE0_EN1 = 4'h2;
    localparam logic [3:0] OFS_GPE0_EN2 = 4'h3;
    localparam logic [3:0] OFS_GPE1_STS1 = 4'h4;
    localparam logic [3:0] OFS_GPE1_EN1 = 4'h6;
    localparam logic [3:0] OFS_GBL_CTRL = 4'h8;

    // Source positions in the status and enable registers
    localparam int unsigned SRC_SERIAL_B = 0;
    localparam int unsigned SRC_SERIAL_A = 1;
    localparam int unsigned SRC_FLOPPY = 2;
    localparam int unsigned SRC_PRINTER = 3;
    localparam int unsigned SRC_KEYBOARD = 4;
    localparam int unsigned SRC_POINTER = 5;

    // Single-bit field positions
    localparam int unsigned FW_FLAG_BIT = 0;
    localparam int unsigned FW_MASK_BIT = 0;
    localparam int unsigned GLOBAL_RELEASE_BIT_BIT = 2;

    // Reset values
    localparam logic [5:0] SRC_RST = 6'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Register access request from the I/O decode
    typedef struct packed {
        logic [3:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;

    // Interrupt requests of the six sources
    typedef struct packed {
        logic pointer;
        logic keyboard;
        logic printer;
        logic floppy;
        logic serial_a;
        logic serial_b;
    } src_irq_t;

endpackage

// *** design/gpe_sci_smi_event_logic.sv ***
`timescale 1ns/1ns

// Notes on behaviour
// - Status bits 0 to 5 of the first event-0 status register are set by serial B, serial A, floppy, printer, keyboard and pointer requests in that order.
// - The first event-0 enable register holds one mask bit per source at bits 0 to 5 in the same order, with bits 6 and 7 reserved.
// - The SCI output is the OR over the six sources of each flag ANDed with its mask.
// - The second event-0 status and enable registers are reserved and always read as zero.
// - The event-0 enable register has six mask bits and the event-1 status register one flag bit; other bits read zero and both reset to zero.
// - The firmware flag at bit 0 of the event-1 status register sets whenever the global release bit becomes set, bits 1 to 7 reserved.
// - With the firmware mask set, setting the global release bit raises the SMI event.
// - Writing one to bit 0 of the event-1 status register clears both the firmware flag and the global release bit.
// - Writing zero to the firmware flag position leaves the firmware flag and global release bit unchanged.
// - Each source flag is cleared by writing one to it while its request is low, and writing zero has no effect.
// - While a source flag stays set, further requests from that source cause no new SCI event.
module gpe_sci_smi_event_logic #(
    // Source count and register width; the port structs fix both
    parameter int unsigned SRC_COUNT = gpe_event_pkg::NUM_SRC,
    parameter int unsigned DATA_W = gpe_event_pkg::REG_W
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // I/O register access
    input wire gpe_event_pkg::io_req_t io_req_i,
    output logic [7:0] io_rdata_o,
    // Peripheral interrupt requests, same clock
    input wire gpe_event_pkg::src_irq_t src_irq_i,
    // Event outputs, active high
    output logic sci_o,
    output logic smi_o
);
    import gpe_event_pkg::*;

    // The ports carry six requests and byte-wide data, so nothing else can be served
    if (SRC_COUNT != $bits(src_irq_t) || DATA_W != REG_W) begin : g_param_check
        $error("event logic supports only six sources and byte registers");
    end

    typedef struct packed {
        logic [5:0] event_flag;
        logic [5:0] event_mask;
        logic firmware_event_flag;
        logic firmware_event_mask;
        logic global_release_bit;
        logic sci;
        logic smi;
        logic [7:0] rdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic hit(input io_req_t req, input logic [3:0] ofs);
        hit = (req.addr == ofs);
    endfunction

    function automatic logic [7:0] pad_src(input logic [5:0] v);
        pad_src = {2'h0, v};
    endfunction

    // Places one flag at its field position, all other bits read zero
    function automatic logic [7:0] place_bit(input logic b, input int unsigned pos);
        place_bit = ZERO_BYTE;
        place_bit[pos] = b;
    endfunction

    logic [5:0] irq_vec;
    logic wr_sts0;
    logic wr_en0;
    logic wr_sts1;
    logic wr_en1;
    logic wr_ctrl;
    logic gbl_set;
    logic gbl_clr;
    logic [5:0] flag_clr;

    assign irq_vec[SRC_SERIAL_B] = src_irq_i.serial_b;
    assign irq_vec[SRC_SERIAL_A] = src_irq_i.serial_a;
    assign irq_vec[SRC_FLOPPY] = src_irq_i.floppy;
    assign irq_vec[SRC_PRINTER] = src_irq_i.printer;
    assign irq_vec[SRC_KEYBOARD] = src_irq_i.keyboard;
    assign irq_vec[SRC_POINTER] = src_irq_i.pointer;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_nxt = state_r;
        wr_sts0 = 1'b0;
        wr_en0 = 1'b0;
        wr_sts1 = 1'b0;
        wr_en1 = 1'b0;
        wr_ctrl = 1'b0;
        if (io_req_i.wr) begin
            if (hit(io_req_i, OFS_GPE0_STS1)) begin
                wr_sts0 = 1'b1;
            end else if (hit(io_req_i, OFS_GPE0_EN1)) begin
                wr_en0 = 1'b1;
            end else if (hit(io_req_i, OFS_GPE1_STS1)) begin
                wr_sts1 = 1'b1;
            end else if (hit(io_req_i, OFS_GPE1_EN1)) begin
                wr_en1 = 1'b1;
            end else if (hit(io_req_i, OFS_GBL_CTRL)) begin
                wr_ctrl = 1'b1;
            end
        end
        // Write one clears, zero is ignored; a live request wins over the clear
        flag_clr = wr_sts0 ? io_req_i.wdata[5:0] : SRC_RST;
        state_nxt.event_flag = (state_r.event_flag & ~flag_clr) | irq_vec;
        if (wr_en0) begin
            state_nxt.event_mask = io_req_i.wdata[5:0];
        end
        if (wr_en1) begin
            state_nxt.firmware_event_mask = io_req_i.wdata[FW_MASK_BIT];
        end
        gbl_set = wr_ctrl && io_req_i.wdata[GLOBAL_RELEASE_BIT_BIT] && !state_r.global_release_bit;
        gbl_clr = wr_sts1 && io_req_i.wdata[FW_FLAG_BIT];
        // Zero at the flag position touches neither bit
        if (gbl_set) begin
            state_nxt.global_release_bit = 1'b1;
        end else if (gbl_clr) begin
            state_nxt.global_release_bit = 1'b0;
        end
        if (gbl_set) begin
            state_nxt.firmware_event_flag = 1'b1;
        end else if (gbl_clr) begin
            state_nxt.firmware_event_flag = 1'b0;
        end
        // Outputs are taken from the next flags so they move with the flag itself
        state_nxt.sci = |(state_nxt.event_flag & state_nxt.event_mask);
        state_nxt.smi = state_nxt.firmware_event_flag & state_nxt.firmware_event_mask;
        state_nxt.rdata = ZERO_BYTE;
        if (io_req_i.rd) begin
            if (hit(io_req_i, OFS_GPE0_STS1)) begin
                state_nxt.rdata = pad_src(state_r.event_flag);
            end else if (hit(io_req_i, OFS_GPE0_STS2)) begin
                state_nxt.rdata = ZERO_BYTE;
            end else if (hit(io_req_i, OFS_GPE0_EN1)) begin
                state_nxt.rdata = pad_src(state_r.event_mask);
            end else if (hit(io_req_i, OFS_GPE0_EN2)) begin
                state_nxt.rdata = ZERO_BYTE;
            end else if (hit(io_req_i, OFS_GPE1_STS1)) begin
                state_nxt.rdata = place_bit(state_r.firmware_event_flag, FW_FLAG_BIT);
            end else if (hit(io_req_i, OFS_GPE1_EN1)) begin
                state_nxt.rdata = place_bit(state_r.firmware_event_mask, FW_MASK_BIT);
            end else if (hit(io_req_i, OFS_GBL_CTRL)) begin
                state_nxt.rdata = place_bit(state_r.global_release_bit, GLOBAL_RELEASE_BIT_BIT);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= '0;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    assign io_rdata_o = state_r.rdata;
    assign sci_o = state_r.sci;
    assign smi_o = state_r.smi;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_gbl_write;
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GBL_CTRL && io_req_i.wdata[GLOBAL_RELEASE_BIT_BIT];
    endsequence

    sequence s_fw_ack;
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GPE1_STS1 && io_req_i.wdata[FW_FLAG_BIT];
    endsequence

    property p_release_smi;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_gbl_write ##0 (!state_r.global_release_bit && state_r.firmware_event_mask && !io_req_i.rd)
            |=> smi_o && state_r.firmware_event_flag;
    endproperty

    a_src_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && src_irq_i.floppy |=> state_r.event_flag[SRC_FLOPPY])
        else $error("floppy request did not set its flag");

    a_src_flag_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GPE0_STS1 && io_req_i.wdata[SRC_SERIAL_A]
            && !src_irq_i.serial_a |=> !state_r.event_flag[SRC_SERIAL_A])
        else $error("write one did not clear serial A flag");

    a_src_flag_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_r.event_flag[SRC_POINTER] && !(ce_i && io_req_i.wr && io_req_i.addr == OFS_GPE0_STS1)
            |=> state_r.event_flag[SRC_POINTER])
        else $error("pointer flag dropped without a clear");

    a_sci_combine: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sci_o == |(state_r.event_flag & state_r.event_mask))
        else $error("sci does not match flags and masks");

    a_mask_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GPE0_EN1 |=> state_r.event_mask == $past(io_req_i.wdata[5:0]))
        else $error("enable register write lost");

    a_rsvd_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.rd && (io_req_i.addr == OFS_GPE0_STS2 || io_req_i.addr == OFS_GPE0_EN2)
            |=> io_rdata_o == ZERO_BYTE)
        else $error("reserved register read not zero");

    a_mask_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.rd && io_req_i.addr == OFS_GPE0_EN1 |=> io_rdata_o == {2'h0, $past(state_r.event_mask)})
        else $error("enable readback wrong");

    a_fw_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(state_r.global_release_bit) |-> state_r.firmware_event_flag)
        else $error("firmware flag missed the release");

    a_release_smi: assert property (p_release_smi)
        else $error("release write did not raise smi");

    a_ack_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_fw_ack |=> !state_r.firmware_event_flag && !state_r.global_release_bit
            && !smi_o)
        else $error("acknowledge did not clear flag and release");

    a_zero_ack_keeps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GPE1_STS1 && !io_req_i.wdata[FW_FLAG_BIT]
            |=> $stable(state_r.global_release_bit) && $stable(state_r.firmware_event_flag))
        else $error("zero write changed firmware flag");

    a_reset_quiet: assert property (@(posedge sys_clk_i)
        $fell(rst_i) |-> !sci_o && !smi_o && state_r.event_mask == SRC_RST)
        else $error("outputs active after reset");

    a_freeze: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !ce_i |=> $stable(state_r))
        else $error("state moved with enable low");

    // Every source sets its own flag a cycle after its request, and nothing else sets it
    for (genvar i = 0; i < SRC_COUNT; i++) begin : g_flag_chk
        a_src_flag_each: assert property (@(posedge sys_clk_i) disable iff (rst_i)
            ce_i && irq_vec[i] |=> state_r.event_flag[i])
            else $error("source request did not set its flag");
        a_src_flag_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
            !state_r.event_flag[i] && !(ce_i && irq_vec[i]) |=> !state_r.event_flag[i])
            else $error("source flag set without its request");
    end

    // A set masked flag holds sci up until software clears the flag or the mask
    a_no_retrigger: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        sci_o && !(io_req_i.wr && (io_req_i.addr == OFS_GPE0_STS1 || io_req_i.addr == OFS_GPE0_EN1))
            |=> sci_o)
        else $error("sci dropped while a masked flag stayed set");

    a_smi_combine: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        smi_o == (state_r.firmware_event_flag && state_r.firmware_event_mask))
        else $error("smi does not match firmware flag and mask");

    a_status_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.rd && io_req_i.addr == OFS_GPE0_STS1
            |=> io_rdata_o == {2'h0, $past(state_r.event_flag)})
        else $error("status readback wrong");

    a_fw_mask_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GPE1_EN1
            |=> state_r.firmware_event_mask == $past(io_req_i.wdata[FW_MASK_BIT]))
        else $error("firmware mask write lost");

    a_release_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.rd && io_req_i.addr == OFS_GBL_CTRL
            |=> io_rdata_o == ({7'h00, $past(state_r.global_release_bit)} << GLOBAL_RELEASE_BIT_BIT))
        else $error("global release readback wrong");

    // Only a one at the release position arms the firmware event
    a_release_zero_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.wr && io_req_i.addr == OFS_GBL_CTRL && !io_req_i.wdata[GLOBAL_RELEASE_BIT_BIT]
            |=> $stable(state_r.global_release_bit) && $stable(state_r.firmware_event_flag))
        else $error("zero write moved the global release bit");

    a_release_rearm: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_gbl_write ##0 state_r.global_release_bit
            |=> state_r.global_release_bit && state_r.firmware_event_flag)
        else $error("repeated release write disturbed the firmware flag");

    a_rsvd_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && io_req_i.wr && (io_req_i.addr == OFS_GPE0_STS2 || io_req_i.addr == OFS_GPE0_EN2)
            |=> $stable(state_r.event_mask) && $stable(state_r.firmware_event_mask))
        else $error("reserved register write changed a mask");

    a_read_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && !io_req_i.rd |=> io_rdata_o == ZERO_BYTE)
        else $error("read data did not return to zero");

    sequence s_fw_raised;
        smi_o && state_r.global_release_bit;
    endsequence

    // Raise then acknowledge: the event stays up until the handler clears it, then falls
    a_smi_handshake: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_fw_raised ##0 s_fw_ack |=> !smi_o && !state_r.global_release_bit)
        else $error("acknowledge of a raised event left smi up");

endmodule // gpe_sci_smi_event_logic

// *** verification/periph_irq_model.sv ***
`timescale 1ns/1ns

module periph_irq_model (
    // Requests from the bench, one bit a source
    input wire logic [5:0] raise_i,
    // Level requests toward the event logic
    output gpe_event_pkg::src_irq_t src_irq_o
);
    import gpe_event_pkg::*;

    // Peripheral lines are plain levels, held as long as the bench holds them
    assign src_irq_o.serial_b = raise_i[SRC_SERIAL_B];
    assign src_irq_o.serial_a = raise_i[SRC_SERIAL_A];
    assign src_irq_o.floppy = raise_i[SRC_FLOPPY];
    assign src_irq_o.printer = raise_i[SRC_PRINTER];
    assign src_irq_o.keyboard = raise_i[SRC_KEYBOARD];
    assign src_irq_o.pointer = raise_i[SRC_POINTER];
endmodule // periph_irq_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
    import gpe_event_pkg::*;

    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    io_req_t req = '0;
    logic [5:0] raise = 6'h00;
    src_irq_t irq;
    logic [7:0] rdata;
    logic sci;
    logic smi;
    logic [7:0] got;
    logic [7:0] m;
    int bad_count = 0;
    int n_compared = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    periph_irq_model model (.raise_i(raise), .src_irq_o(irq));
    gpe_sci_smi_event_logic dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .io_req_i(req),
        .io_rdata_o(rdata), .src_irq_i(irq), .sci_o(sci), .smi_o(smi));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t read got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t event output got %b expected %b", $time, g, e);
        end
    endtask

    // Every access ends at the falling edge so that outputs have settled
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge sys_clk_i);
        req.wr <= 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge sys_clk_i);
        req.rd <= 1'b0;
        @(negedge sys_clk_i);
        d = rdata;
    endtask

    task automatic src_pulse(input logic [5:0] s);
        @(posedge sys_clk_i);
        raise <= s;
        @(posedge sys_clk_i);
        raise <= 6'h00;
        @(negedge sys_clk_i);
    endtask

    task automatic test_done;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // The whole sequence needs well under 1000 cycles
    initial begin
        #100000;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk_bit(sci, 1'b0);
        chk_bit(smi, 1'b0);
        for (int a = 0; a < 16; a++) begin
            reg_rd(a[3:0], got);
            chk_byte(got, 8'h00);
        end
        reg_wr(OFS_GPE0_STS2, 8'hff);
        reg_wr(OFS_GPE0_EN2, 8'hff);
        reg_wr(OFS_GPE0_EN1, 8'hff);
        reg_rd(OFS_GPE0_STS2, got);
        chk_byte(got, 8'h00);
        reg_rd(OFS_GPE0_EN2, got);
        chk_byte(got, 8'h00);
        reg_rd(OFS_GPE0_EN1, got);
        chk_byte(got, 8'h3f);
        // Read data stands for one cycle only
        @(negedge sys_clk_i);
        chk_byte(rdata, 8'h00);
        // Each source alone: masked first, then unmasked, then acknowledged
        for (int i = 0; i < NUM_SRC; i++) begin
            m = 8'h01 << i;
            reg_wr(OFS_GPE0_EN1, 8'h3f & ~m);
            src_pulse(m[5:0]);
            reg_rd(OFS_GPE0_STS1, got);
            chk_byte(got, m);
            chk_bit(sci, 1'b0);
            reg_wr(OFS_GPE0_EN1, m);
            chk_bit(sci, 1'b1);
            reg_wr(OFS_GPE0_STS1, ~m);
            chk_bit(sci, 1'b1);
            reg_wr(OFS_GPE0_STS1, m);
            chk_bit(sci, 1'b0);
        end
        // A request still high beats the clear written in the same cycle
        reg_wr(OFS_GPE0_EN1, 8'h3f);
        @(posedge sys_clk_i);
        raise <= 6'h10;
        reg_wr(OFS_GPE0_STS1, 8'h10);
        reg_rd(OFS_GPE0_STS1, got);
        chk_byte(got, 8'h10);
        chk_bit(sci, 1'b1);
        @(posedge sys_clk_i);
        raise <= 6'h00;
        reg_wr(OFS_GPE0_STS1, 8'h10);
        chk_bit(sci, 1'b0);
        // Enable low: a write and a request are both ignored
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        reg_wr(OFS_GPE0_EN1, 8'h00);
        src_pulse(6'h02);
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        @(negedge sys_clk_i);
        chk_bit(sci, 1'b0);
        reg_rd(OFS_GPE0_STS1, got);
        chk_byte(got, 8'h00);
        reg_rd(OFS_GPE0_EN1, got);
        chk_byte(got, 8'h3f);
        // Firmware event, first with its mask off
        reg_wr(OFS_GBL_CTRL, 8'h04);
        chk_bit(smi, 1'b0);
        reg_rd(OFS_GPE1_STS1, got);
        chk_byte(got, 8'h01);
        reg_wr(OFS_GPE1_STS1, 8'h01);
        reg_rd(OFS_GBL_CTRL, got);
        chk_byte(got, 8'h00);
        reg_wr(OFS_GPE1_EN1, 8'h01);
        reg_wr(OFS_GBL_CTRL, 8'h04);
        chk_bit(smi, 1'b1);
        reg_wr(OFS_GBL_CTRL, 8'h04);
        chk_bit(smi, 1'b1);
        reg_wr(OFS_GBL_CTRL, 8'hfb);
        chk_bit(smi, 1'b1);
        reg_wr(OFS_GPE1_STS1, 8'hfe);
        chk_bit(smi, 1'b1);
        reg_rd(OFS_GBL_CTRL, got);
        chk_byte(got, 8'h04);
        reg_wr(OFS_GPE1_STS1, 8'h01);
        chk_bit(smi, 1'b0);
        reg_rd(OFS_GPE1_STS1, got);
        chk_byte(got, 8'h00);
        // Reset in mid-run with masks set and one flag pending
        src_pulse(6'h01);
        chk_bit(sci, 1'b1);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk_bit(sci, 1'b0);
        reg_rd(OFS_GPE0_EN1, got);
        chk_byte(got, 8'h00);
        reg_rd(OFS_GPE1_EN1, got);
        chk_byte(got, 8'h00);
        test_done();
    end
endmodule // tb_top
